// ---- verilog/bcdrtc_pkg.sv ----
// Shared constants, types and BCD helpers of the BCD real-time clock register block.
package bcdrtc_pkg;

  // Clock rate and derived tick counts.
  localparam int CLK_PERIOD_NS = 8;
  localparam int SECOND_NS = 1_000_000_000;
  localparam int PROBE_HZ = 512;
  localparam int SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;
  localparam int PROBE_HALF_CYCLES = SECOND_NS / (2 * PROBE_HZ * CLK_PERIOD_NS);

  // Register addresses on the byte-wide bus.
  localparam int ADDR_W = 19;
  localparam logic [18:0] ADDR_CENTURY_AND_HOLD_CONTROL = 19'h7fff8;
  localparam logic [18:0] ADDR_SECONDS_AND_OSC_STOP = 19'h7fff9;
  localparam logic [18:0] ADDR_MINUTES_COUNT = 19'h7fffa;
  localparam logic [18:0] ADDR_HOURS_COUNT = 19'h7fffb;
  localparam logic [18:0] ADDR_WEEKDAY_AND_STATUS = 19'h7fffc;
  localparam logic [18:0] ADDR_DAY_OF_MONTH_COUNT = 19'h7fffd;
  localparam logic [18:0] ADDR_MONTH_COUNT = 19'h7fffe;
  localparam logic [18:0] ADDR_YEAR_COUNT = 19'h7ffff;

  // Register indices, taken from the low three address bits.
  localparam logic [2:0] IDX_CEN = 3'h0;
  localparam logic [2:0] IDX_SEC = 3'h1;
  localparam logic [2:0] IDX_MIN = 3'h2;
  localparam logic [2:0] IDX_HOUR = 3'h3;
  localparam logic [2:0] IDX_DAY = 3'h4;
  localparam logic [2:0] IDX_DATE = 3'h5;
  localparam logic [2:0] IDX_MONTH = 3'h6;
  localparam logic [2:0] IDX_YEAR = 3'h7;

  // Control and status bit positions.
  localparam int WRITE_HOLD_BIT = 7;
  localparam int READ_HOLD_BIT = 6;
  localparam int STOP_TICKING_BIT = 7;
  localparam int TICK_PROBE_BIT = 6;
  localparam int BATTERY_OK_BIT = 7;

  // Counter values after reset.
  localparam logic [7:0] RST_SEC = 8'h00;
  localparam logic [7:0] RST_MIN = 8'h00;
  localparam logic [7:0] RST_HOUR = 8'h00;
  localparam logic [7:0] RST_DAY = 8'h01;
  localparam logic [7:0] RST_DATE = 8'h01;
  localparam logic [7:0] RST_MONTH = 8'h01;
  localparam logic [7:0] RST_YEAR = 8'h00;
  localparam logic [7:0] RST_CEN = 8'h20;

  // Bus phase of the host interface.
  typedef enum logic [0:0] {BUS_IDLE, BUS_WRITING} bcdrtc_bus_type;

  // Bits of each register that hold count digits; the rest are stored as zero.
  function automatic logic [7:0] field_mask(input logic [2:0] idx);
    case (idx)
      IDX_CEN: field_mask = 8'h3f;
      IDX_SEC: field_mask = 8'h7f;
      IDX_MIN: field_mask = 8'h7f;
      IDX_HOUR: field_mask = 8'h3f;
      IDX_DAY: field_mask = 8'h07;
      IDX_DATE: field_mask = 8'h3f;
      IDX_MONTH: field_mask = 8'h1f;
      default: field_mask = 8'hff;
    endcase
  endfunction : field_mask

  // Adds one to a two-digit BCD value.
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] >= 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction : bcd_inc

  // Converts a two-digit BCD value to binary.
  function automatic logic [6:0] bcd_to_bin(input logic [7:0] v);
    bcd_to_bin = 7'(v[7:4] * 4'ha) + 7'(v[3:0]);
  endfunction : bcd_to_bin

  // Last date of a month in BCD, with leap years including the century rule.
  function automatic logic [7:0] month_days(input logic [7:0] month, input logic [7:0] year,
                                            input logic [7:0] cen);
    logic [6:0] y;
    logic [6:0] c;
    logic leap;
    y = bcd_to_bin(year);
    c = bcd_to_bin(cen);
    leap = (y[1:0] == 2'h0) && ((y != 7'h00) || (c[1:0] == 2'h0));
    case (month)
      8'h02: month_days = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
      default: month_days = 8'h31;
    endcase
  endfunction : month_days

endpackage : bcdrtc_pkg

// ---- verilog/bcdrtc_divider.sv ----
// Oscillator divider giving the one-second tick and the 512 Hz probe toggle.
`timescale 1ns/1ps
module bcdrtc_divider import bcdrtc_pkg::*; #(
  parameter int SEC_COUNT = SEC_CYCLES,
  parameter int HALF_COUNT = PROBE_HALF_CYCLES
) (
  // Clock, reset and enable.
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Oscillator control and outputs.
  input wire logic run_in,
  output logic sec_tick_out,
  output logic probe_toggle_out
);

  if (SEC_COUNT < 2 || HALF_COUNT < 1) begin : g_bad_counts
    $error("bcdrtc_divider: tick counts too small");
  end

  logic [$clog2(SEC_COUNT)-1:0] sec_cnt_q;
  logic [$clog2(HALF_COUNT+1)-1:0] half_cnt_q;

  // Second divider; it freezes while the oscillator is stopped.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sec_cnt_q <= '0;
      sec_tick_out <= 1'b0;
    end else if (ce_in) begin
      sec_tick_out <= 1'b0;
      if (run_in) begin
        if (sec_cnt_q == ($clog2(SEC_COUNT))'(SEC_COUNT - 1)) begin
          sec_cnt_q <= '0;
          sec_tick_out <= 1'b1;
        end else begin
          sec_cnt_q <= sec_cnt_q + 1'b1;
        end
      end
    end
  end

  // Probe toggle, flipping every half period of 512 Hz.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      half_cnt_q <= '0;
      probe_toggle_out <= 1'b0;
    end else if (ce_in && run_in) begin
      if (half_cnt_q == ($clog2(HALF_COUNT+1))'(HALF_COUNT - 1)) begin
        half_cnt_q <= '0;
        probe_toggle_out <= ~probe_toggle_out;
      end else begin
        half_cnt_q <= half_cnt_q + 1'b1;
      end
    end
  end

endmodule : bcdrtc_divider

// ---- verilog/bcdrtc_calendar.sv ----
// Internal BCD timekeeping counters with month length and leap year correction.
`timescale 1ns/1ps
module bcdrtc_calendar import bcdrtc_pkg::*; (
  // Clock, reset and enable.
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Tick and load.
  input wire logic sec_tick_in,
  input wire logic load_in,
  input wire logic [7:0] load_val_in [8],
  // Running counts, indexed like the registers.
  output logic [7:0] count_out [8]
);

  logic [7:0] sec_q, min_q, hour_q, day_q, date_q, month_q, year_q, cen_q;
  logic c_min, c_hour, c_day, c_month, c_year, c_cen;

  // Carry chain of the calendar.
  always_comb begin
    c_min = sec_tick_in && (sec_q == 8'h59);
    c_hour = c_min && (min_q == 8'h59);
    c_day = c_hour && (hour_q == 8'h23);
    c_month = c_day && (date_q == month_days(month_q, year_q, cen_q));
    c_year = c_month && (month_q == 8'h12);
    c_cen = c_year && (year_q == 8'h99);
  end

  // Counters keep running regardless of any hold on the visible registers.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      sec_q <= RST_SEC;
      min_q <= RST_MIN;
      hour_q <= RST_HOUR;
      day_q <= RST_DAY;
      date_q <= RST_DATE;
      month_q <= RST_MONTH;
      year_q <= RST_YEAR;
      cen_q <= RST_CEN;
    end else if (ce_in) begin
      if (load_in) begin
        sec_q <= load_val_in[IDX_SEC];
        min_q <= load_val_in[IDX_MIN];
        hour_q <= load_val_in[IDX_HOUR];
        day_q <= load_val_in[IDX_DAY];
        date_q <= load_val_in[IDX_DATE];
        month_q <= load_val_in[IDX_MONTH];
        year_q <= load_val_in[IDX_YEAR];
        cen_q <= load_val_in[IDX_CEN];
      end else if (sec_tick_in) begin
        sec_q <= c_min ? 8'h00 : bcd_inc(sec_q);
        if (c_min) min_q <= c_hour ? 8'h00 : bcd_inc(min_q);
        if (c_hour) hour_q <= c_day ? 8'h00 : bcd_inc(hour_q);
        if (c_day) day_q <= (day_q == 8'h07) ? 8'h01 : bcd_inc(day_q);
        if (c_day) date_q <= c_month ? 8'h01 : bcd_inc(date_q);
        if (c_month) month_q <= c_year ? 8'h01 : bcd_inc(month_q);
        if (c_year) year_q <= c_cen ? 8'h00 : bcd_inc(year_q);
        if (c_cen) cen_q <= (cen_q == 8'h39) ? 8'h00 : bcd_inc(cen_q);
      end
    end
  end

  // Counts presented in register order.
  assign count_out[IDX_CEN] = cen_q;
  assign count_out[IDX_SEC] = sec_q;
  assign count_out[IDX_MIN] = min_q;
  assign count_out[IDX_HOUR] = hour_q;
  assign count_out[IDX_DAY] = day_q;
  assign count_out[IDX_DATE] = date_q;
  assign count_out[IDX_MONTH] = month_q;
  assign count_out[IDX_YEAR] = year_q;

  // Calendar checks.
  chk_day_wrap: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && !load_in && c_day && day_q == 8'h07) |=> (day_q == 8'h01))
    else $error("weekday did not wrap to one");
  chk_units_bcd: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && !load_in && sec_tick_in && sec_q[3:0] == 4'h9) |=> (sec_q[3:0] == 4'h0))
    else $error("seconds units left BCD range");
  chk_leap_day: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && !load_in && c_day && month_q == 8'h02 && date_q == 8'h28
     && (year_q == 8'h24 || (year_q == 8'h00 && cen_q == 8'h20)))
    |=> (date_q == 8'h29 && month_q == 8'h02))
    else $error("leap day skipped");
  chk_short_month: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && !load_in && c_day && month_q == 8'h04 && date_q == 8'h30)
    |=> (date_q == 8'h01 && month_q == 8'h05))
    else $error("thirty-day month did not roll");

endmodule : bcdrtc_calendar

// ---- verilog/bcdrtc_regs.sv ----
// Host-facing register file of the BCD real-time clock with hold bits and double buffering.
//
// Functional notes
// - All time and date values are kept and shown as two BCD digits.
// - Weekday advances at midnight and wraps within 01 to 07.
// - While read hold is one, counts stop moving into visible registers.
// - During read hold visible registers keep the time when the hold was set.
// - Internal counters keep counting during any hold.
// - After hold release all visible registers refresh together within one second.
// - Setting write hold halts visible updates so the host can load registers.
// - Writing 00h to clear write hold loads the visible values into counters.
// - Writing 00h to clear read hold resumes from the running counts.
// - A control write setting a hold bit leaves the century field unchanged.
// - A control write clearing write hold without setting read hold stores the written century field.
// - A control write clearing only read hold leaves the century field unchanged.
// - Stop bit in seconds register halts the oscillator; zero lets it run.
// - With probe bit set and oscillator running, seconds LSB toggles at 512 Hz.
// - A steady read of seconds shows the probe toggle on data line zero.
// - Chip select and output enable low, write enable high, drives read data.
// - Write while chip select and write enable are low, address held stable.
// - Weekday bit 7 reads battery status and ignores host writes.
// - Date rollover follows month length and leap years.
`timescale 1ns/1ps
module bcdrtc_regs import bcdrtc_pkg::*; #(
  parameter int SEC_COUNT = SEC_CYCLES,
  parameter int HALF_COUNT = PROBE_HALF_CYCLES
) (
  // Clock, reset and enable.
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // Byte-wide host bus.
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic chip_sel_n_in,
  input wire logic out_en_n_in,
  input wire logic wr_en_n_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n_out,
  // Battery monitor.
  input wire logic battery_ok_in
);

  if (SEC_COUNT < 2 * HALF_COUNT) begin : g_bad_ratio
    $error("bcdrtc_regs: second must exceed one probe period");
  end

  bcdrtc_bus_type bus_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [7:0] wdata_q;
  logic commit;
  logic wr_act;
  logic rd_act;
  logic rd_hit;
  logic [2:0] widx;
  logic [2:0] ridx;
  logic w_hold_q;
  logic r_hold_q;
  logic stop_ticking_q;
  logic tick_probe_q;
  logic [7:0] vis_q [8];
  logic [7:0] cnt [8];
  logic [7:0] load_val [8];
  logic load;
  logic ctrl_wr;
  logic time_wr;
  logic sec_tick;
  logic probe_tog;
  logic [7:0] rd_mux;

  // Decodes the top eight addresses as clock registers.
  function automatic logic is_rtc(input logic [ADDR_W-1:0] a);
    is_rtc = (a[ADDR_W-1:3] == ADDR_CENTURY_AND_HOLD_CONTROL[ADDR_W-1:3]);
  endfunction : is_rtc

  // Bus decode of the strobes.
  assign wr_act = !chip_sel_n_in && !wr_en_n_in;
  assign rd_act = !chip_sel_n_in && !out_en_n_in && wr_en_n_in;
  assign rd_hit = rd_act && is_rtc(addr_in);
  assign data_oe_n_out = !rd_hit;
  assign widx = waddr_q[2:0];
  assign ridx = addr_in[2:0];
  assign commit = (bus_q == BUS_WRITING) && !wr_act;
  assign ctrl_wr = commit && is_rtc(waddr_q) && (widx == IDX_CEN);
  assign time_wr = commit && is_rtc(waddr_q) && (widx != IDX_CEN);

  // Write cycle: address and data follow the bus while active, taken when it ends.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      bus_q <= BUS_IDLE;
      waddr_q <= '0;
      wdata_q <= 8'h00;
    end else if (ce_in) begin
      case (bus_q)
        BUS_IDLE: begin
          if (wr_act) begin
            bus_q <= BUS_WRITING;
            waddr_q <= addr_in;
            wdata_q <= data_in;
          end
        end
        BUS_WRITING: begin
          if (wr_act) begin
            waddr_q <= addr_in;
            wdata_q <= data_in;
          end else begin
            bus_q <= BUS_IDLE;
          end
        end
        default: bus_q <= BUS_IDLE;
      endcase
    end
  end

  // Hold bits follow each control write.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      w_hold_q <= 1'b0;
      r_hold_q <= 1'b0;
    end else if (ce_in && ctrl_wr) begin
      w_hold_q <= wdata_q[WRITE_HOLD_BIT];
      r_hold_q <= wdata_q[READ_HOLD_BIT];
    end
  end

  // Oscillator stop and probe bits live beside the count fields.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      stop_ticking_q <= 1'b0;
      tick_probe_q <= 1'b0;
    end else if (ce_in && time_wr) begin
      if (widx == IDX_SEC) stop_ticking_q <= wdata_q[STOP_TICKING_BIT];
      if (widx == IDX_DAY) tick_probe_q <= wdata_q[TICK_PROBE_BIT];
    end
  end

  // Values loaded into the counters: the held visible set, or the running counts with no
  // write hold so that a direct write never rewinds the other fields, with the write merged in.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      load_val[i] = w_hold_q ? vis_q[i] : cnt[i];
      if (time_wr && widx == 3'(i)) load_val[i] = wdata_q & field_mask(3'(i));
    end
    if (ctrl_wr) load_val[IDX_CEN] = wdata_q & field_mask(IDX_CEN);
  end

  // Counters load on write-hold release, or on a direct write with no hold.
  assign load = (ctrl_wr && wdata_q[7:6] == 2'b00 && w_hold_q)
             || (time_wr && !w_hold_q && !r_hold_q);

  // Visible registers: host writes land here; counts copy in only with no hold.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      vis_q <= '{RST_CEN, RST_SEC, RST_MIN, RST_HOUR, RST_DAY, RST_DATE, RST_MONTH, RST_YEAR};
    end else if (ce_in) begin
      if (time_wr) begin
        vis_q[widx] <= wdata_q & field_mask(widx);
      end else if (ctrl_wr) begin
        if (wdata_q[7:6] == 2'b00 && w_hold_q) begin
          vis_q[IDX_CEN] <= wdata_q & field_mask(IDX_CEN);
        end else if (wdata_q[7:6] == 2'b00 && !r_hold_q) begin
          vis_q[IDX_CEN] <= wdata_q & field_mask(IDX_CEN);
        end
      end else if (!w_hold_q && !r_hold_q) begin
        vis_q <= cnt;
      end
    end
  end

  // Read data assembled from visible registers and live status bits.
  always_comb begin
    rd_mux = vis_q[ridx];
    if (ridx == IDX_CEN) begin
      rd_mux[WRITE_HOLD_BIT] = w_hold_q;
      rd_mux[READ_HOLD_BIT] = r_hold_q;
    end else if (ridx == IDX_SEC) begin
      rd_mux[STOP_TICKING_BIT] = stop_ticking_q;
      if (tick_probe_q && !stop_ticking_q) rd_mux[0] = probe_tog;
    end else if (ridx == IDX_DAY) begin
      rd_mux[BATTERY_OK_BIT] = battery_ok_in;
      rd_mux[TICK_PROBE_BIT] = tick_probe_q;
    end
  end

  // Read data register, refreshed every enabled cycle from the current address.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      data_out <= 8'h00;
    end else if (ce_in) begin
      data_out <= rd_hit ? rd_mux : 8'h00;
    end
  end

  // Oscillator divider.
  bcdrtc_divider #(
    .SEC_COUNT(SEC_COUNT),
    .HALF_COUNT(HALF_COUNT)
  ) u_divider (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .run_in(!stop_ticking_q),
    .sec_tick_out(sec_tick),
    .probe_toggle_out(probe_tog)
  );

  // Running calendar.
  bcdrtc_calendar u_calendar (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .sec_tick_in(sec_tick),
    .load_in(load),
    .load_val_in(load_val),
    .count_out(cnt)
  );

  // Register behaviour checks.
  chk_read_hold_frozen: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && r_hold_q && !commit) |=> $stable(vis_q[IDX_MIN]) && $stable(vis_q[IDX_SEC]))
    else $error("visible time moved during read hold");
  chk_refresh_all: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && !w_hold_q && !r_hold_q && !commit)
    |=> (vis_q[IDX_SEC] == $past(cnt[IDX_SEC]) && vis_q[IDX_YEAR] == $past(cnt[IDX_YEAR])))
    else $error("visible registers not refreshed together");
  chk_century_kept: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && ctrl_wr && wdata_q[7:6] != 2'b00) |=> $stable(vis_q[IDX_CEN]))
    else $error("century changed by hold-setting write");
  chk_century_load: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && ctrl_wr && wdata_q[7:6] == 2'b00 && w_hold_q)
    |=> (vis_q[IDX_CEN] == ($past(wdata_q) & 8'h3f)))
    else $error("century not written on write-hold release");
  chk_century_rclear: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && ctrl_wr && wdata_q == 8'h00 && r_hold_q && !w_hold_q) |=> $stable(vis_q[IDX_CEN]))
    else $error("century changed by read-hold release");
  chk_wclear_loads: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && ctrl_wr && wdata_q == 8'h00 && w_hold_q)
    |=> (cnt[IDX_MIN] == $past(vis_q[IDX_MIN]) && !w_hold_q))
    else $error("write-hold release did not load counters");
  chk_hold_isolates: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && time_wr && w_hold_q && widx == IDX_YEAR && !sec_tick)
    |=> $stable(cnt[IDX_YEAR]))
    else $error("write under hold reached running year");
  chk_stop_halts: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && stop_ticking_q) ##1 stop_ticking_q |-> !sec_tick)
    else $error("second tick while oscillator stopped");
  chk_probe_line: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && rd_hit && ridx == IDX_SEC && tick_probe_q && !stop_ticking_q && $changed(probe_tog))
    |=> (data_out[0] == $past(probe_tog)))
    else $error("data line zero did not follow probe");
  chk_battery_bit: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (ce_in && rd_hit && ridx == IDX_DAY) |=> (data_out[BATTERY_OK_BIT] == $past(battery_ok_in)))
    else $error("battery status not reported");

  // Main scenarios.
  cov_read_hold: cover property (@(posedge clk_sys_in) disable iff (reset_in)
    ctrl_wr && wdata_q[READ_HOLD_BIT] ##[1:20] ctrl_wr && wdata_q == 8'h00);
  cov_write_load: cover property (@(posedge clk_sys_in) disable iff (reset_in)
    load && w_hold_q);
  cov_probe_read: cover property (@(posedge clk_sys_in) disable iff (reset_in)
    rd_hit && ridx == IDX_SEC && tick_probe_q && $changed(probe_tog));

endmodule : bcdrtc_regs

// ---- testbench/bcdrtc_host.sv ----
// Host processor model driving the byte-wide clock register bus.
`timescale 1ns/1ps
module bcdrtc_host import bcdrtc_pkg::*; (
  // Clock.
  input wire logic clk_sys_in,
  // Bus towards the device.
  output logic [ADDR_W-1:0] addr_out,
  output logic chip_sel_n_out,
  output logic out_en_n_out,
  output logic wr_en_n_out,
  output logic [7:0] data_out,
  // Answer from the device.
  input wire logic [7:0] data_in,
  input wire logic data_oe_n_in
);
  // The bus starts deselected.
  initial begin
    addr_out = 19'h00000;
    chip_sel_n_out = 1'b1;
    out_en_n_out = 1'b1;
    wr_en_n_out = 1'b1;
    data_out = 8'h00;
  end

  // One write; callers may set ignored bits such as weekday bit 7 and pass weekdays in any order.
  task automatic wr(input logic [2:0] idx, input logic [7:0] val);
    @(posedge clk_sys_in) #1;
    addr_out = {16'hffff, idx};
    data_out = val;
    chip_sel_n_out = 1'b0;
    wr_en_n_out = 1'b0;
    @(posedge clk_sys_in) #1;
    chip_sel_n_out = 1'b1;
    wr_en_n_out = 1'b1;
    data_out = ~val; // Released data does not keep its old value.
    @(posedge clk_sys_in) #1;
  endtask : wr

  // A read held steady for extra cycles, counting changes of data line zero.
  task automatic rd(input logic [18:0] addr, input int cycles, output logic [7:0] val,
                    output logic oe_n, output int flips);
    logic [7:0] prev;
    flips = 0;
    @(posedge clk_sys_in) #1;
    addr_out = addr;
    chip_sel_n_out = 1'b0;
    out_en_n_out = 1'b0;
    @(posedge clk_sys_in) #1;
    prev = data_in;
    oe_n = data_oe_n_in;
    repeat (cycles) begin
      @(posedge clk_sys_in) #1;
      flips += int'(data_in[0] != prev[0]);
      prev = data_in;
    end
    val = prev;
    chip_sel_n_out = 1'b1;
    out_en_n_out = 1'b1;
    @(posedge clk_sys_in) #1;
  endtask : rd
endmodule : bcdrtc_host

// ---- testbench/test_bcdrtc_regs.sv ----
// Self-checking testbench of the clock register block.
`timescale 1ns/1ps
module test_bcdrtc_regs import bcdrtc_pkg::*;;
  localparam int SEC_T = 40;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic battery_ok_in = 1'b1;
  logic ce = 1'b1;
  logic rd_oe_n;
  logic [ADDR_W-1:0] addr;
  logic cs_n, oe_n, we_n, doe_n;
  logic [7:0] wdata, rdata, v, s0;
  logic [7:0] wv [8];
  logic [31:0] seed = 32'h2f332412;
  int fails = 0;
  int compares = 0;
  int f;

  // Clock at 125 MHz.
  always #4 clk_sys_in = ~clk_sys_in;

  bcdrtc_regs #(.SEC_COUNT(SEC_T), .HALF_COUNT(4)) i_bcdrtc_regs (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .ce_in(ce), .addr_in(addr), .chip_sel_n_in(cs_n),
    .out_en_n_in(oe_n), .wr_en_n_in(we_n), .data_in(wdata), .data_out(rdata),
    .data_oe_n_out(doe_n), .battery_ok_in(battery_ok_in));
  bcdrtc_host i_bcdrtc_host (.clk_sys_in(clk_sys_in), .addr_out(addr), .chip_sel_n_out(cs_n),
    .out_en_n_out(oe_n), .wr_en_n_out(we_n), .data_out(wdata), .data_in(rdata),
    .data_oe_n_in(doe_n));

  // Next random value and the BCD form of a number below 100.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    xs = s ^ (s << 5);
  endfunction : xs
  function automatic logic [7:0] bcd(input int v);
    bcd = 8'((v / 10) * 16 + v % 10);
  endfunction : bcd

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte
  task automatic chk_bit(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  // Reads one clock register and checks that the device drives the bus.
  task automatic rdv(input logic [2:0] idx, output logic [7:0] val);
    logic o;
    int n;
    i_bcdrtc_host.rd({16'hffff, idx}, 0, val, o, n);
    chk_bit("read drive", 1'b0, o);
  endtask : rdv

  task automatic give_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  // Watchdog far beyond the expected run length.
  initial begin
    #400000;
    fails++;
    give_verdict();
  end

  initial begin
    repeat (4) @(posedge clk_sys_in);
    #1 reset_in = 1'b0;
    // Load the last second of 28 February 2000 with weekday 07.
    i_bcdrtc_host.wr(IDX_CEN, 8'h80);
    wv = '{8'h20, 8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h00};
    for (int i = 1; i < 8; i++) i_bcdrtc_host.wr(3'(i), wv[i]);
    i_bcdrtc_host.wr(IDX_CEN, 8'h20);
    repeat (SEC_T + 6) @(posedge clk_sys_in);
    i_bcdrtc_host.wr(IDX_CEN, 8'h55);
    wv = '{8'h60, 8'h00, 8'h00, 8'h00, 8'h81, 8'h29, 8'h02, 8'h00};
    for (int i = 2; i < 8; i++) begin
      rdv(3'(i), v);
      chk_byte("rollover", wv[i], v);
    end
    rdv(IDX_CEN, v);
    chk_byte("century held", 8'h60, v);
    rdv(IDX_SEC, s0);
    chk_bit("first second", 1'b1, s0 <= 8'h01);
    repeat (2 * SEC_T + 4) @(posedge clk_sys_in);
    rdv(IDX_SEC, v);
    chk_byte("frozen seconds", s0, v);
    i_bcdrtc_host.wr(IDX_CEN, 8'h00);
    repeat (6) @(posedge clk_sys_in);
    rdv(IDX_CEN, v);
    chk_byte("century kept", 8'h20, v);
    rdv(IDX_SEC, v);
    chk_bit("count ran on", 1'b1, v >= s0 + 8'h02 && v <= s0 + 8'h03);
    // Random settings written under write hold read back unchanged, with weekday bit 7 showing battery status.
    repeat (4) begin
      seed = xs(seed);
      battery_ok_in = seed[31];
      wv = '{8'h80, bcd(seed % 60), bcd(seed[15:8] % 60), bcd(seed[23:16] % 24),
             {~seed[31], 4'h0, 3'(seed % 7 + 1)}, bcd(seed[27:20] % 28 + 1),
             bcd(seed[12:5] % 12 + 1), bcd(seed[30:24] % 100)};
      for (int i = 0; i < 8; i++) i_bcdrtc_host.wr(3'(i), wv[i]);
      for (int i = 1; i < 8; i++) begin
        rdv(3'(i), v);
        chk_byte("loaded value", i == 4 ? {seed[31], wv[i][6:0]} : wv[i], v);
      end
    end
    battery_ok_in = 1'b1;
    i_bcdrtc_host.wr(IDX_CEN, 8'h20);
    // Stopped oscillator keeps seconds and blocks the probe toggle.
    i_bcdrtc_host.wr(IDX_DAY, 8'h41);
    i_bcdrtc_host.wr(IDX_SEC, 8'h80);
    i_bcdrtc_host.rd(ADDR_SECONDS_AND_OSC_STOP, 2 * SEC_T, v, rd_oe_n, f);
    chk_byte("stopped seconds", 8'h80, v);
    chk_bit("stopped probe", 1'b1, f == 0);
    i_bcdrtc_host.wr(IDX_SEC, 8'h00);
    i_bcdrtc_host.rd(ADDR_SECONDS_AND_OSC_STOP, 32, v, rd_oe_n, f);
    chk_bit("probe toggles", 1'b1, f >= 7 && f <= 9);
    i_bcdrtc_host.wr(IDX_DAY, 8'h01);
    i_bcdrtc_host.rd(19'h00000, 0, v, s0[0], f);
    chk_bit("unmapped drive", 1'b1, s0[0]);
    // Clock enable low for three seconds' worth of cycles freezes the count.
    rdv(IDX_SEC, s0);
    ce = 1'b0;
    repeat (3 * SEC_T) @(posedge clk_sys_in);
    #1 ce = 1'b1;
    rdv(IDX_SEC, v);
    chk_byte("enable freeze", s0, v);
    give_verdict();
  end
endmodule : test_bcdrtc_regs
